// *** hw/i2c_slave_ctl_defs.svh ***
// Register indices, field positions, codes and reset values of the I2C slave control slice
`ifndef I2C_SLAVE_CTL_DEFS_SVH
`define I2C_SLAVE_CTL_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_CTRL 10'h004
`define IDX_ADDRESS 10'h009
`define IDX_DATA 10'h00c
`define IDX_IRQ_ENABLE_CLEAR 10'h014
`define IDX_IRQ_ENABLE_SET 10'h016
`define IDX_EVENT_FLAG 10'h018
`define IDX_EVENT_FLAG_CLEAR 10'h019
`define IDX_STATUS 10'h01a

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_ACK_SEL_BIT 18
`define CTRL_CMD_LSB 16
`define CTRL_SCHEME_LSB 14
`define CTRL_AUTO_ACK_BIT 10
`define CTRL_GROUP_BIT 9
`define CTRL_SMART_BIT 8

// ****************************************************************
// Address register fields
// ****************************************************************
`define ADDR_PRIMARY_LSB 0
`define ADDR_SECONDARY_LSB 16

// ****************************************************************
// Event flag and enable bit positions
// ****************************************************************
`define EV_ERROR_BIT 7
`define EV_BYTE_BIT 2
`define EV_ADDR_BIT 1
`define EV_STOP_BIT 0
`define EV_USED_MASK 8'h87

// ****************************************************************
// Status register fields
// ****************************************************************
`define STAT_DIR_BIT 3
`define STAT_BUSY_BIT 4

// ****************************************************************
// Command codes and reset values
// ****************************************************************
`define CMD_COMPLETE 2'h2
`define CMD_RESPOND 2'h3
`define RESET_IRQ_ENABLE 8'h00
`define RESET_EVENT_FLAG 8'h00
`define RESET_ADDRESS 7'h00

`endif

// *** hw/i2c_slave_ctl_pkg.sv ***
// Types shared by the I2C slave control slice and its bit engine
package i2c_slave_ctl_pkg;

    // Address recognition schemes
    typedef enum logic [1:0]
    {
        scheme_mask = 2'b00,
        scheme_dual = 2'b01,
        scheme_range = 2'b10,
        scheme_reserved = 2'b11
    } address_match_scheme_type;

    // Action handed to the bit engine
    typedef enum logic [2:0]
    {
        act_none = 3'b000,
        act_receive_next = 3'b001,
        act_send_first = 3'b010,
        act_shift_out = 3'b011,
        act_wait_start = 3'b100
    } action_type;

    // Events reported by the bit engine, one-cycle pulses with data
    typedef struct packed
    {
        logic addr_seen;
        logic [6:0] addr_value;
        logic dir;
        logic byte_done;
        logic bus_stop;
        logic bus_error;
        logic [7:0] rx_byte;
    } engine_in_type;

    // Order to the bit engine
    typedef struct packed
    {
        logic go;
        logic send_nack;
        action_type action;
        logic address_hit;
    } engine_cmd_type;

    // Complete state of the control slice
    typedef struct packed
    {
        logic ack_response_select;
        address_match_scheme_type address_match_scheme;
        logic auto_address_ack_on;
        logic group_command_support;
        logic read_triggers_ack;
        logic [6:0] primary_address;
        logic [6:0] secondary_match_value;
        logic [7:0] irq_enable;
        logic [7:0] event_flag_register;
        logic [7:0] rx_byte;
        logic dir;
        logic in_transfer;
        logic addressed_since_stop;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        engine_cmd_type cmd;
    } ctl_state_type;

endpackage

// *** hw/i2c_slave_ctl.sv ***
// I2C slave control slice: commands, address recognition, events and interrupt enables
`timescale 1ns/1ps
`include "i2c_slave_ctl_defs.svh"

module i2c_slave_ctl
    import i2c_slave_ctl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire engine_in_type engine_in,
    output engine_cmd_type engine_cmd,
    output logic irq
);

    // ****************************************************************
    // Address recognition
    // ****************************************************************

    // Decides whether an incoming address belongs to this slave
    function automatic logic address_matches(
        input address_match_scheme_type scheme,
        input logic [6:0] primary,
        input logic [6:0] secondary,
        input logic [6:0] incoming
    );
        logic hit;
        hit = 1'b0;
        unique case (scheme)
            scheme_mask:
            begin
                hit = (((incoming ^ primary) & ~secondary) == 7'h00);
            end
            scheme_dual:
            begin
                hit = (incoming == primary) || (incoming == secondary);
            end
            scheme_range:
            begin
                hit = (incoming >= secondary) && (incoming <= primary);
            end
            scheme_reserved:
            begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************

    ctl_state_type st; // Registered state
    ctl_state_type next_st; // Next state
    logic access_first; // First access cycle, answer being prepared
    logic access_done; // Access edge: pready sampled high
    logic [9:0] idx; // Register index from the byte address
    logic aligned; // Byte address is word aligned
    logic mapped; // Address hits a register
    logic wr; // Write taking effect this edge
    logic rd; // Read taking effect this edge
    logic [1:0] cmd_code; // Command field of a control write
    logic [31:0] read_mux; // Read value for the current address

    assign idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign access_first = psel && penable && !st.pready;
    assign access_done = psel && penable && st.pready;
    assign wr = access_done && pwrite && !st.pslverr;
    assign rd = access_done && !pwrite && !st.pslverr;
    assign cmd_code = pwdata[`CTRL_CMD_LSB +: 2];

    // Outputs straight from the state flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign engine_cmd = st.cmd;
    assign irq = st.irq;

    // ****************************************************************
    // Register read decode
    // ****************************************************************

    // Selects the read value and flags unmapped addresses
    always_comb
    begin
        read_mux = 32'h0000_0000;
        mapped = aligned;
        unique case (idx)
            `IDX_CTRL:
            begin
                // Command field always reads zero
                read_mux[`CTRL_ACK_SEL_BIT] = st.ack_response_select;
                read_mux[`CTRL_SCHEME_LSB +: 2] = st.address_match_scheme;
                read_mux[`CTRL_AUTO_ACK_BIT] = st.auto_address_ack_on;
                read_mux[`CTRL_GROUP_BIT] = st.group_command_support;
                read_mux[`CTRL_SMART_BIT] = st.read_triggers_ack;
            end
            `IDX_ADDRESS:
            begin
                read_mux[`ADDR_PRIMARY_LSB +: 7] = st.primary_address;
                read_mux[`ADDR_SECONDARY_LSB +: 7] = st.secondary_match_value;
            end
            `IDX_DATA:
            begin
                read_mux[7:0] = st.rx_byte;
            end
            `IDX_IRQ_ENABLE_CLEAR, `IDX_IRQ_ENABLE_SET:
            begin
                read_mux[7:0] = st.irq_enable;
            end
            `IDX_EVENT_FLAG:
            begin
                read_mux[7:0] = st.event_flag_register;
            end
            `IDX_EVENT_FLAG_CLEAR:
            begin
                read_mux = 32'h0000_0000;
            end
            `IDX_STATUS:
            begin
                read_mux[`STAT_DIR_BIT] = st.dir;
                read_mux[`STAT_BUSY_BIT] = st.in_transfer;
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Bus slave, software effects, then hardware events so sets win
    always_comb
    begin
        logic hit;
        logic cmd_valid;
        hit = 1'b0;
        cmd_valid = 1'b0;
        next_st = st;

        // Engine orders are one-cycle pulses
        next_st.cmd.go = 1'b0;
        next_st.cmd.address_hit = 1'b0;
        next_st.cmd.action = act_none;

        // Two-cycle access: pready follows the first access cycle
        next_st.pready = access_first;
        next_st.pslverr = access_first && !mapped;
        if (access_first)
        begin
            next_st.prdata = read_mux;
        end

        // Register writes
        if (wr)
        begin
            unique case (idx)
                `IDX_CTRL:
                begin
                    next_st.ack_response_select = pwdata[`CTRL_ACK_SEL_BIT];
                    next_st.address_match_scheme = address_match_scheme_type'(pwdata[`CTRL_SCHEME_LSB +: 2]);
                    next_st.auto_address_ack_on = pwdata[`CTRL_AUTO_ACK_BIT];
                    next_st.group_command_support = pwdata[`CTRL_GROUP_BIT];
                    next_st.read_triggers_ack = pwdata[`CTRL_SMART_BIT];
                    cmd_valid = (cmd_code == `CMD_RESPOND) || (cmd_code == `CMD_COMPLETE);
                end
                `IDX_ADDRESS:
                begin
                    next_st.primary_address = pwdata[`ADDR_PRIMARY_LSB +: 7];
                    next_st.secondary_match_value = pwdata[`ADDR_SECONDARY_LSB +: 7];
                end
                `IDX_IRQ_ENABLE_CLEAR:
                begin
                    next_st.irq_enable = st.irq_enable & ~(pwdata[7:0] & `EV_USED_MASK);
                end
                `IDX_IRQ_ENABLE_SET:
                begin
                    next_st.irq_enable = st.irq_enable | (pwdata[7:0] & `EV_USED_MASK);
                end
                `IDX_EVENT_FLAG_CLEAR:
                begin
                    next_st.event_flag_register = st.event_flag_register & ~pwdata[7:0];
                end
                default:
                begin
                    next_st.cmd.go = 1'b0;
                end
            endcase
        end

        // Software command strobe
        if (cmd_valid)
        begin
            next_st.cmd.go = 1'b1;
            // Ack select written together with the command applies to it
            next_st.cmd.send_nack = pwdata[`CTRL_ACK_SEL_BIT];
            if (cmd_code == `CMD_COMPLETE)
            begin
                next_st.cmd.action = act_wait_start;
            end
            else if (st.event_flag_register[`EV_ADDR_BIT])
            begin
                if (st.dir)
                begin
                    next_st.cmd.action = act_send_first;
                end
                else
                begin
                    next_st.cmd.action = act_receive_next;
                end
            end
            else if (st.dir)
            begin
                next_st.cmd.action = act_shift_out;
            end
            else
            begin
                next_st.cmd.action = act_receive_next;
            end
            next_st.event_flag_register[`EV_BYTE_BIT] = 1'b0;
            next_st.event_flag_register[`EV_ADDR_BIT] = 1'b0;
            next_st.event_flag_register[`EV_STOP_BIT] = 1'b0;
            // A read transfer asks for its first byte at once
            if ((cmd_code == `CMD_RESPOND) && st.event_flag_register[`EV_ADDR_BIT] && st.dir)
            begin
                next_st.event_flag_register[`EV_BYTE_BIT] = 1'b1;
            end
        end

        // Smart mode: reading the data performs the ack action
        if (rd && (idx == `IDX_DATA) && st.read_triggers_ack && st.event_flag_register[`EV_BYTE_BIT])
        begin
            next_st.cmd.go = 1'b1;
            next_st.cmd.send_nack = st.ack_response_select;
            next_st.cmd.action = st.dir ? act_shift_out : act_receive_next;
            next_st.event_flag_register[`EV_BYTE_BIT] = 1'b0;
        end

        // Address seen on the bus
        if (engine_in.addr_seen)
        begin
            hit = address_matches(st.address_match_scheme, st.primary_address,
                st.secondary_match_value, engine_in.addr_value);
            next_st.in_transfer = hit;
            if (hit)
            begin
                next_st.addressed_since_stop = 1'b1;
                next_st.dir = engine_in.dir;
                next_st.cmd.address_hit = 1'b1;
                if (st.auto_address_ack_on)
                begin
                    // Acknowledge without waiting for software
                    next_st.cmd.go = 1'b1;
                    next_st.cmd.send_nack = 1'b0;
                    next_st.cmd.action = engine_in.dir ? act_send_first : act_receive_next;
                    if (engine_in.dir)
                    begin
                        next_st.event_flag_register[`EV_BYTE_BIT] = 1'b1;
                    end
                end
                else
                begin
                    next_st.event_flag_register[`EV_ADDR_BIT] = 1'b1;
                end
            end
        end

        // Byte finished on the bus
        if (engine_in.byte_done && st.in_transfer)
        begin
            next_st.rx_byte = engine_in.rx_byte;
            next_st.event_flag_register[`EV_BYTE_BIT] = 1'b1;
        end

        // Stop on the bus
        if (engine_in.bus_stop)
        begin
            if (st.in_transfer || (st.group_command_support && st.addressed_since_stop))
            begin
                next_st.event_flag_register[`EV_STOP_BIT] = 1'b1;
            end
            next_st.in_transfer = 1'b0;
            next_st.addressed_since_stop = 1'b0;
        end

        // Bus error
        if (engine_in.bus_error)
        begin
            next_st.event_flag_register[`EV_ERROR_BIT] = 1'b1;
        end

        // Interrupt level from the next flags and enables
        next_st.irq = |(next_st.event_flag_register & next_st.irq_enable);
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Synchronous active-low reset to constants
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.address_match_scheme <= scheme_mask;
            st.primary_address <= `RESET_ADDRESS;
            st.secondary_match_value <= `RESET_ADDRESS;
            st.irq_enable <= `RESET_IRQ_ENABLE;
            st.event_flag_register <= `RESET_EVENT_FLAG;
            st.cmd.action <= act_none;
        end
        else
        begin
            st <= next_st;
        end
    end

endmodule

// *** sim/i2c_slave_ctl_properties.sv ***
// Port checker of the I2C slave control slice
`timescale 1ns/1ps
`include "i2c_slave_ctl_defs.svh"
module i2c_slave_ctl_properties
    import i2c_slave_ctl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire engine_in_type engine_in,
    input wire engine_cmd_type engine_cmd,
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ****
    // Completed accesses
    // ****
    logic done; // Access ends at this edge
    logic ctl_wr; // Control word written
    assign done = psel && penable && pready;
    assign ctl_wr = done && pwrite && paddr == {`IDX_CTRL, 2'b00};
    a_ready_one_wait: assert property ($rose(penable) && psel |=> pready)
        else $error("answer not one wait state");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_cmd_reads_zero: assert property (done && !pwrite && paddr == {`IDX_CTRL, 2'b00} |-> prdata[17:16] == 2'b00)
        else $error("command field read nonzero");
    a_respond_go_nack: assert property (ctl_wr && pwdata[17:16] == `CMD_RESPOND
        |=> engine_cmd.go && engine_cmd.send_nack == $past(pwdata[`CTRL_ACK_SEL_BIT]))
        else $error("respond command not issued");
    a_complete_wait: assert property (ctl_wr && pwdata[17:16] == `CMD_COMPLETE
        |=> engine_cmd.go && engine_cmd.action == act_wait_start)
        else $error("complete command not issued");
    a_idle_code_quiet: assert property (ctl_wr && !pwdata[17] && !engine_in.addr_seen |=> !engine_cmd.go)
        else $error("idle code issued an action");
    a_action_with_go: assert property (!engine_cmd.go |-> engine_cmd.action == act_none)
        else $error("action without go");
    a_hit_has_cause: assert property (engine_cmd.address_hit |-> $past(engine_in.addr_seen))
        else $error("hit without address");
    a_no_go_in_reset: assert property (engine_cmd.go |-> $past(rst_b))
        else $error("go right after reset");
    cover property (engine_cmd.go && engine_cmd.action == act_shift_out);
    cover property (pslverr);
    cover property ($rose(irq));
endmodule

bind i2c_slave_ctl i2c_slave_ctl_properties i2c_slave_ctl_properties_inst (.core_clk(core_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .engine_in(engine_in), .engine_cmd(engine_cmd), .irq(irq));

// *** sim/i2c_master_model.sv ***
// Behavioural far side: bus events in, engine orders watched
`timescale 1ns/1ps
module i2c_master_model
    import i2c_slave_ctl_pkg::*;
(
    input wire logic core_clk,
    output engine_in_type engine_in,
    input wire engine_cmd_type engine_cmd
);
    int go_count = 0; // Orders seen
    int hit_count = 0; // Address hits seen
    action_type last_action = act_none; // Last order
    logic last_nack = 1'b0; // Response of last order
    initial engine_in = '0;
    // Record orders and hits
    always @(posedge core_clk)
    begin
        if (engine_cmd.go === 1'b1)
        begin
            go_count <= go_count + 1;
            last_action <= engine_cmd.action;
            last_nack <= engine_cmd.send_nack;
        end
        if (engine_cmd.address_hit === 1'b1)
            hit_count <= hit_count + 1;
    end
    // One event pulse: 0 address, 1 byte, 2 stop, 3 error
    task automatic ev(input int k, input logic [7:0] v, input logic d);
        engine_in_type e;
        e = '0;
        e.addr_seen = (k == 0);
        e.addr_value = v[6:0];
        e.dir = d;
        e.byte_done = (k == 1);
        e.bus_stop = (k == 2);
        e.bus_error = (k == 3);
        e.rx_byte = v;
        @(posedge core_clk);
        engine_in <= e;
        @(posedge core_clk);
        engine_in <= '0;
        @(posedge core_clk);
    endtask
endmodule

// *** sim/i2c_slave_ctl_tb.sv ***
// Self-checking bench of the I2C slave control slice
`timescale 1ns/1ps
`include "i2c_slave_ctl_defs.svh"
module i2c_slave_ctl_tb
    import i2c_slave_ctl_pkg::*;
;
    logic core_clk, rst_b, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq, cfg;
    logic pready, pslverr, irq, rerr;
    engine_in_type engine_in;
    engine_cmd_type engine_cmd;
    int num_errors = 0, comparisons = 0, cycles = 0, g0, h0;
    i2c_slave_ctl i2c_slave_ctl_inst (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .engine_in(engine_in), .engine_cmd(engine_cmd), .irq(irq));
    i2c_master_model i2c_master_model_inst (.core_clk(core_clk), .engine_in(engine_in), .engine_cmd(engine_cmd));
    // ****
    // Clock, timeout and verdict
    // ****
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ****
    // APB master and helpers
    // ****
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the bench timeout ends this wait
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'b1);
        rq = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Read a register and compare
    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rq, exp);
    endtask
    // Event through the far side, then let outputs settle
    task automatic e(input int k, input logic [7:0] v, input logic d);
        i2c_master_model_inst.ev(k, v, d);
        @(posedge core_clk);
    endtask
    // Command strobe on top of the current setup
    task automatic cmd(input logic [1:0] c);
        g0 = i2c_master_model_inst.go_count;
        apb(1'b1, `IDX_CTRL, cfg | {14'h0, c, 16'h0});
        repeat (2) @(posedge core_clk);
    endtask
    task automatic go_chk(input action_type a, input logic n);
        chk(i2c_master_model_inst.go_count - g0, 1);
        chk({29'h0, i2c_master_model_inst.last_action}, {29'h0, a});
        chk({31'h0, i2c_master_model_inst.last_nack}, {31'h0, n});
    endtask
    // End transfer and clear all flags
    task automatic tidy();
        e(2, 8'h00, 1'b0);
        apb(1'b1, `IDX_EVENT_FLAG_CLEAR, 32'hff);
    endtask
    task automatic scheme_case(input logic [1:0] s, input logic [6:0] p, input logic [6:0] q,
        input logic [6:0] a, input int hit);
        cfg = {16'h0, s, 14'h0};
        apb(1'b1, `IDX_CTRL, cfg);
        apb(1'b1, `IDX_ADDRESS, {9'h0, q, 9'h0, p});
        h0 = i2c_master_model_inst.hit_count;
        e(0, {1'b0, a}, 1'b0);
        chk(i2c_master_model_inst.hit_count - h0, hit);
        tidy();
    endtask
    // ****
    // Main sequence
    // ****
    initial
    begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        // Reset values and an unmapped place
        rd(`IDX_IRQ_ENABLE_CLEAR, 32'h0);
        rd(`IDX_IRQ_ENABLE_SET, 32'h0);
        rd(10'h3f0, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("test reset done");
        // Shared enables, write-one semantics
        apb(1'b1, `IDX_IRQ_ENABLE_SET, 32'hff);
        rd(`IDX_IRQ_ENABLE_SET, 32'h87);
        rd(`IDX_IRQ_ENABLE_CLEAR, 32'h87);
        apb(1'b1, `IDX_IRQ_ENABLE_CLEAR, 32'h02);
        rd(`IDX_IRQ_ENABLE_SET, 32'h85);
        apb(1'b1, `IDX_IRQ_ENABLE_CLEAR, 32'h0);
        apb(1'b1, `IDX_IRQ_ENABLE_SET, 32'h0);
        rd(`IDX_IRQ_ENABLE_CLEAR, 32'h85);
        apb(1'b1, `IDX_IRQ_ENABLE_CLEAR, 32'hff);
        rd(`IDX_IRQ_ENABLE_SET, 32'h0);
        $display("test enables done");
        // Schemes with edge values
        scheme_case(2'h0, 7'h50, 7'h0f, 7'h5a, 1);
        scheme_case(2'h0, 7'h50, 7'h0f, 7'h60, 0);
        scheme_case(2'h1, 7'h21, 7'h44, 7'h44, 1);
        scheme_case(2'h1, 7'h21, 7'h44, 7'h21, 1);
        scheme_case(2'h1, 7'h21, 7'h44, 7'h22, 0);
        scheme_case(2'h2, 7'h30, 7'h20, 7'h20, 1);
        scheme_case(2'h2, 7'h30, 7'h20, 7'h30, 1);
        scheme_case(2'h2, 7'h30, 7'h20, 7'h31, 0);
        scheme_case(2'h2, 7'h30, 7'h20, 7'h1f, 0);
        scheme_case(2'h3, 7'h30, 7'h20, 7'h30, 0);
        $display("test schemes done");
        // Commands in both directions; dual scheme 0x21 / 0x44
        cfg = {16'h0, 2'h1, 14'h0};
        apb(1'b1, `IDX_CTRL, cfg);
        apb(1'b1, `IDX_ADDRESS, {9'h0, 7'h44, 9'h0, 7'h21});
        apb(1'b1, `IDX_IRQ_ENABLE_SET, 32'h02);
        e(0, 8'h21, 1'b0);
        chk({31'h0, irq}, 32'h1);
        cmd(2'h3);
        go_chk(act_receive_next, 1'b0);
        rd(`IDX_EVENT_FLAG, 32'h0);
        chk({31'h0, irq}, 32'h0);
        e(1, 8'h3c, 1'b0);
        cmd(2'h3);
        go_chk(act_receive_next, 1'b0);
        rd(`IDX_DATA, 32'h3c);
        tidy();
        e(0, 8'h44, 1'b1);
        rd(`IDX_STATUS, 32'h18);
        cfg[`CTRL_ACK_SEL_BIT] = 1'b1;
        cmd(2'h3);
        go_chk(act_send_first, 1'b1);
        rd(`IDX_EVENT_FLAG, 32'h04);
        cmd(2'h3);
        go_chk(act_shift_out, 1'b1);
        cmd(2'h2);
        go_chk(act_wait_start, 1'b1);
        rd(`IDX_CTRL, cfg);
        for (int c = 0; c < 2; c++)
        begin
            cmd(c[1:0]);
            chk(i2c_master_model_inst.go_count - g0, 0);
        end
        tidy();
        $display("test commands done");
        // Automatic address acknowledge on and off
        cfg = {16'h0, 2'h1, 3'h0, 1'b1, 10'h0};
        apb(1'b1, `IDX_CTRL, cfg);
        g0 = i2c_master_model_inst.go_count;
        e(0, 8'h21, 1'b0);
        go_chk(act_receive_next, 1'b0);
        rd(`IDX_EVENT_FLAG, 32'h0);
        tidy();
        cfg[`CTRL_AUTO_ACK_BIT] = 1'b0;
        apb(1'b1, `IDX_CTRL, cfg);
        g0 = i2c_master_model_inst.go_count;
        e(0, 8'h21, 1'b0);
        chk(i2c_master_model_inst.go_count - g0, 0);
        rd(`IDX_EVENT_FLAG, 32'h02);
        tidy();
        $display("test auto ack done");
        // Data read acknowledges in smart mode
        cfg[`CTRL_SMART_BIT] = 1'b1;
        apb(1'b1, `IDX_CTRL, cfg);
        e(0, 8'h21, 1'b0);
        cmd(2'h3);
        e(1, 8'ha5, 1'b0);
        g0 = i2c_master_model_inst.go_count;
        rd(`IDX_DATA, 32'ha5);
        repeat (2) @(posedge core_clk);
        go_chk(act_receive_next, 1'b0);
        tidy();
        $display("test smart done");
        // Stop after leaving the transfer, with and without group support
        for (int gr = 1; gr >= 0; gr--)
        begin
            cfg = {16'h0, 2'h1, 4'h0, gr[0], 9'h0};
            apb(1'b1, `IDX_CTRL, cfg);
            e(0, 8'h21, 1'b0);
            e(0, 8'h22, 1'b0);
            e(2, 8'h00, 1'b0);
            rd(`IDX_EVENT_FLAG, {30'h0, 1'b1, gr[0]});
            apb(1'b1, `IDX_EVENT_FLAG_CLEAR, 32'hff);
        end
        $display("test group done");
        // Error event raises and drops the interrupt
        apb(1'b1, `IDX_IRQ_ENABLE_SET, 32'h80);
        e(3, 8'h00, 1'b0);
        chk({31'h0, irq}, 32'h1);
        rd(`IDX_EVENT_FLAG, 32'h80);
        apb(1'b1, `IDX_IRQ_ENABLE_CLEAR, 32'h80);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        $display("test error done");
        wrap_up();
    end
endmodule
